//--- pll_div9_consts.svh
// Purpose: offsets, field positions and reset values of the out9/divider
//          configuration slice
// Assumes: 32-bit serial words, register address in word bits 3..0
// Notes:   definitions only
`ifndef PLL_DIV9_CONSTS_SVH
`define PLL_DIV9_CONSTS_SVH

// register addresses carried in word bits 3..0
`define ADDR_OUT9_CFG    4'h9
`define ADDR_DIV_RATIOS  4'hA
`define ADDR_CLK_MUX     4'hB
`define ADDR_MSB         3

// out9 / aux configuration word fields
`define BIT_AUX_BIAS     23
`define BIT_AUX_DIS      24
`define BIT_HI_SWING     25
`define CFGLOW_X         28
`define CFGLOW_Y         29
`define CFGHIGH_X        30
`define CFGHIGH_Y        31

// divider word fields
`define REF_DIV_LSB      4
`define REF_DIV_MSB      17
`define OSC_DIV_LSB      18
`define OSC_DIV_MSB      31

// clock mux word fields
`define BIT_FB_MUX       24
`define BIT_OUT_MUX      25

// serial framing
`define WORD_BITS        6'h20
`define CNT_MAX          6'h3F

// reset values, overwritten by the nonvolatile copy before use
`define RST_BIT          1'b0
`define RST_STD          2'h0
`define RST_DIV          14'h0000

`endif

//--- pll_div9_pkg.sv
// Purpose: types shared by the serial receiver and the config bank
// Assumes: constants come from pll_div9_consts.svh
// Notes:   output standard codes are the {x,y} field pair
package pll_div9_pkg;

    // out9 signaling standard, code is {x,y}
    typedef enum logic [1:0] {
        STD_LVCMOS = 2'h0,
        STD_LVPECL = 2'h1,
        STD_OFF    = 2'h2,
        STD_LVDS   = 2'h3
    } out9_std_t;

    // bank sequencing, one-hot
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } cfg_state_t;

    // serial receiver state
    typedef struct packed {
        logic        prev_clk;
        logic        prev_le;
        logic [5:0]  cnt;
        logic [31:0] shift;
        logic        valid;
        logic [31:0] word;
    } rx_state_t;

    // configuration bank state and registered outputs
    typedef struct packed {
        cfg_state_t  st;
        logic        aux_neg_bias_enable;
        logic        aux_buffer_disable;
        logic        out9_high_swing;
        logic [1:0]  out9_std_cfglow;
        logic [1:0]  out9_std_cfghigh;
        logic        feedback_tree_source_select;
        logic        output_source_select;
        logic [13:0] ref_div;
        logic [13:0] osc_div;
        logic        o_aux_buf_en;
        logic        o_aux_bias;
        out9_std_t   o_std;
        logic        o_swing;
        logic        o_tree_aux;
        logic        o_loaded;
    } cfg_state_s_t;

endpackage : pll_div9_pkg

//--- cfg_word_if.sv
// Purpose: carries one assembled configuration word between modules
// Assumes: single clock domain
// Notes:   valid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface cfg_word_if;
    logic        valid;  // word complete, one cycle
    logic [31:0] word;   // bit 0 = first bit shifted in

    modport src (output valid, output word);
    modport dst (input valid, input word);
endinterface : cfg_word_if
`default_nettype wire

//--- cfg_serial_rx.sv
// Purpose: assembles 32-bit configuration words from the serial host pins
// Assumes: host pins are synchronous to sys_clk and slow against it
// Notes:   a frame that is not exactly 32 bits long is dropped
`timescale 1ns/1ps
`default_nettype none
`include "pll_div9_consts.svh"
module cfg_serial_rx
    import pll_div9_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic spi_clk,
    input  wire logic spi_le_n,
    input  wire logic spi_mosi,
    cfg_word_if.src   out
);
    rx_state_t s;       // registered state
    rx_state_t next_s;  // next state

    // shift on host clock rise while the latch enable is low
    always_comb begin
        next_s          = s;
        next_s.prev_clk = spi_clk;
        next_s.prev_le  = spi_le_n;
        next_s.valid    = 1'b0;
        if (!spi_le_n && spi_clk && !s.prev_clk) begin
            // first bit lands in bit 0 after 32 shifts
            next_s.shift = {spi_mosi, s.shift[31:1]};
            // saturate so an overlong frame is still seen as wrong
            if (s.cnt != `CNT_MAX) begin
                next_s.cnt = s.cnt + 6'h01;
            end
        end else if (spi_le_n && !s.prev_le) begin
            // latch edge closes the frame
            if (s.cnt == `WORD_BITS) begin
                next_s.valid = 1'b1;
                next_s.word  = s.shift;
            end
            next_s.cnt = 6'h00;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{prev_clk: 1'b0, prev_le: 1'b1, cnt: 6'h00,
                   shift: 32'h0, valid: 1'b0, word: 32'h0};
        end else begin
            s <= next_s;
        end
    end

    assign out.valid = s.valid;
    assign out.word  = s.word;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    word_length_a: assert property (
        $rose(s.valid) |-> $past(s.cnt) == `WORD_BITS)
        else $error("word emitted with wrong bit count");

endmodule : cfg_serial_rx
`default_nettype wire

//--- pll_div9_cfg.sv
// Purpose: out9/aux control bits and divider ratios written over the
//          serial host port
// Assumes: nonvolatile copy presented on nvm_* with nvm_ready
// Notes:   decoded outputs follow an accepted word two cycles after valid, the divider ratios one cycle after
`timescale 1ns/1ps
`default_nettype none
`include "pll_div9_consts.svh"
module pll_div9_cfg
    import pll_div9_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        spi_clk,
    input  wire logic        spi_le_n,
    input  wire logic        spi_mosi,
    input  wire logic        config_select_pin,
    input  wire logic        nvm_ready,
    input  wire logic [31:0] nvm_out9_word,
    input  wire logic [31:0] nvm_div_word,
    input  wire logic [31:0] nvm_mux_word,
    output var  logic        aux_buffer_enable,
    output var  logic        aux_neg_bias_connect,
    output var  out9_std_t   out9_std,
    output var  logic        out9_swing_high,
    output var  logic        clock_tree_aux,
    output var  logic [13:0] ref_divider,
    output var  logic [13:0] osc_divider,
    output var  logic        cfg_loaded
);
    cfg_word_if   cfg_bus ();  // assembled host words
    cfg_state_s_t s;           // registered state
    cfg_state_s_t next_s;      // next state

    cfg_serial_rx u_rx (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .spi_clk  (spi_clk),
        .spi_le_n (spi_le_n),
        .spi_mosi (spi_mosi),
        .out      (cfg_bus.src)
    );

    // store the fields of one word; other addresses are ignored
    function automatic cfg_state_s_t apply_word(input cfg_state_s_t c,
                                                input logic [31:0] w);
        cfg_state_s_t r;
        r = c;
        if (w[`ADDR_MSB:0] == `ADDR_OUT9_CFG) begin
            // reserved bits 26 and 27 are not kept
            r.aux_neg_bias_enable = w[`BIT_AUX_BIAS];
            r.aux_buffer_disable  = w[`BIT_AUX_DIS];
            r.out9_high_swing     = w[`BIT_HI_SWING];
            r.out9_std_cfglow     = {w[`CFGLOW_X], w[`CFGLOW_Y]};
            r.out9_std_cfghigh    = {w[`CFGHIGH_X], w[`CFGHIGH_Y]};
        end else if (w[`ADDR_MSB:0] == `ADDR_DIV_RATIOS) begin
            // both ratios come in one word, never half of it
            r.ref_div = w[`REF_DIV_MSB:`REF_DIV_LSB];
            r.osc_div = w[`OSC_DIV_MSB:`OSC_DIV_LSB];
        end else if (w[`ADDR_MSB:0] == `ADDR_CLK_MUX) begin
            // only the two select bits matter to this slice
            r.feedback_tree_source_select = w[`BIT_FB_MUX];
            r.output_source_select        = w[`BIT_OUT_MUX];
        end
        return r;
    endfunction : apply_word

    // sequencing, field storage and output decode
    always_comb begin
        next_s = s;
        case (s.st)
            ST_LOAD: begin
                // host words are dropped until the stored copy is in
                if (nvm_ready) begin
                    next_s = apply_word(next_s, nvm_out9_word);
                    next_s = apply_word(next_s, nvm_div_word);
                    next_s = apply_word(next_s, nvm_mux_word);
                    next_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // a word is applied whole, the cycle after it closes
                if (cfg_bus.valid) begin
                    next_s = apply_word(s, cfg_bus.word);
                end
            end
            default: begin
                // an illegal state code falls back to a fresh load
                next_s.st = ST_LOAD;
            end
        endcase
        // outputs decode the current fields, one cycle behind them
        next_s.o_aux_buf_en = !s.aux_buffer_disable &&
            (s.feedback_tree_source_select || s.output_source_select);
        next_s.o_aux_bias = s.aux_neg_bias_enable;
        // select pin picks the field pair; codes map straight over
        if (config_select_pin) begin
            // pin high, upper field pair
            next_s.o_std = out9_std_t'(s.out9_std_cfghigh);
        end else begin
            // pin low, lower field pair
            next_s.o_std = out9_std_t'(s.out9_std_cfglow);
        end
        // high swing only means something in the PECL standard
        next_s.o_swing = s.out9_high_swing &&
                         (next_s.o_std == STD_LVPECL);
        next_s.o_tree_aux = s.feedback_tree_source_select;
        next_s.o_loaded   = (s.st == ST_RUN);
    end

    // state register, everything from one flop bank
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{st: ST_LOAD,
                   aux_neg_bias_enable: `RST_BIT,
                   aux_buffer_disable: `RST_BIT,
                   out9_high_swing: `RST_BIT,
                   out9_std_cfglow: `RST_STD,
                   out9_std_cfghigh: `RST_STD,
                   feedback_tree_source_select: `RST_BIT,
                   output_source_select: `RST_BIT,
                   ref_div: `RST_DIV,
                   osc_div: `RST_DIV,
                   o_aux_buf_en: 1'b0,
                   o_aux_bias: 1'b0,
                   o_std: STD_LVCMOS,
                   o_swing: 1'b0,
                   o_tree_aux: 1'b0,
                   o_loaded: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the flop bank
    assign aux_buffer_enable    = s.o_aux_buf_en;
    assign aux_neg_bias_connect = s.o_aux_bias;
    assign out9_std             = s.o_std;
    assign out9_swing_high      = s.o_swing;
    assign clock_tree_aux       = s.o_tree_aux;
    assign ref_divider          = s.ref_div;
    assign osc_divider          = s.osc_div;
    assign cfg_loaded           = s.o_loaded;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // a host word stands on cfg_bus.valid for one cycle, the fields take
    // it at the next edge and the decoded outputs follow one edge later;
    // checks on decoded outputs therefore compare against the fields as
    // they were sampled one cycle earlier, not as they are now

    aux_buf_off_a: assert property (
        s.aux_buffer_disable |=> !aux_buffer_enable)
        else $error("aux buffer on while disabled");
    aux_buf_follow_a: assert property (
        (!s.aux_buffer_disable && (s.feedback_tree_source_select ||
         s.output_source_select)) |=> aux_buffer_enable)
        else $error("aux buffer not following mux selects");
    aux_bias_a: assert property (
        ##1 aux_neg_bias_connect == $past(s.aux_neg_bias_enable))
        else $error("aux bias does not follow its bit");
    swing_pecl_a: assert property (
        out9_swing_high |-> out9_std == STD_LVPECL)
        else $error("high swing outside PECL");
    std_low_a: assert property (
        (!config_select_pin && $stable(s.out9_std_cfglow))
        |=> out9_std == out9_std_t'($past(s.out9_std_cfglow)))
        else $error("low-select standard wrong");
    std_high_a: assert property (
        (config_select_pin && $stable(s.out9_std_cfghigh))
        |=> out9_std == out9_std_t'($past(s.out9_std_cfghigh)))
        else $error("high-select standard wrong");
    std_off_a: assert property (
        (!config_select_pin && s.out9_std_cfglow == 2'h2)
        |=> out9_std == STD_OFF)
        else $error("code 10 did not disable out9");
    ref_div_a: assert property (
        (cfg_bus.valid && cfg_bus.word[3:0] == `ADDR_DIV_RATIOS &&
         s.st == ST_RUN) |=> ref_divider == $past(cfg_bus.word[17:4]))
        else $error("reference divider not taken");
    osc_div_a: assert property (
        (cfg_bus.valid && cfg_bus.word[3:0] == `ADDR_DIV_RATIOS &&
         s.st == ST_RUN) |=> osc_divider == $past(cfg_bus.word[31:18]))
        else $error("oscillator divider not taken");
    tree_src_a: assert property (
        ##1 clock_tree_aux == $past(s.feedback_tree_source_select))
        else $error("clock tree source wrong");
    nvm_first_a: assert property (
        (s.st == ST_LOAD && !nvm_ready) |=> $stable(s.ref_div) &&
        s.st == ST_LOAD)
        else $error("fields changed before nonvolatile load");

    // a word for an address outside this slice must leave both divider fields and both standard fields
    unmapped_addr_a: assert property (
        (s.st == ST_RUN && cfg_bus.valid &&
         cfg_bus.word[3:0] != `ADDR_OUT9_CFG &&
         cfg_bus.word[3:0] != `ADDR_DIV_RATIOS &&
         cfg_bus.word[3:0] != `ADDR_CLK_MUX)
        |=> $stable(s.ref_div) && $stable(s.osc_div) &&
            $stable(s.out9_std_cfglow) && $stable(s.out9_std_cfghigh))
        else $error("unmapped address changed a field");
    // swing must really come on, not merely stay off outside PECL
    swing_on_a: assert property (
        (s.out9_high_swing && out9_std_t'(config_select_pin ?
         s.out9_std_cfghigh : s.out9_std_cfglow) == STD_LVPECL)
        |=> out9_swing_high)
        else $error("high swing not applied in PECL");

    // scenarios the bench is expected to reach

    div_write_c: cover property (
        cfg_bus.valid && cfg_bus.word[3:0] == `ADDR_DIV_RATIOS &&
        s.st == ST_RUN);
    pin_swap_c: cover property (
        $changed(config_select_pin) && s.o_loaded);
    pecl_swing_c: cover property (out9_swing_high);
    lvds_low_c: cover property (
        !config_select_pin && out9_std == STD_LVDS);
    nvm_load_c: cover property ($rose(cfg_loaded));

endmodule : pll_div9_cfg
`default_nettype wire

//--- spi_host_model.sv
// Purpose: serial host that shifts configuration words into the block
// Assumes: driven on the falling sys_clk edge, one cycle per clock phase
// Notes:   data line shows the inverted last bit once released
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic sys_clk,
    output var  logic spi_clk,
    output var  logic spi_le_n,
    output var  logic spi_mosi
);
    // idle: latch high, clock parked low
    initial begin
        spi_clk  = 1'b0;
        spi_le_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // one frame of n bits; n below 32 makes a frame the block drops
    task automatic send(input logic [31:0] w, input int n);
        int i;
        @(negedge sys_clk) spi_le_n = 1'b0;
        for (i = 0; i < n; i++) begin
            @(negedge sys_clk);
            spi_mosi = w[i];
            spi_clk  = 1'b1;
            @(negedge sys_clk) spi_clk = 1'b0;
        end
        // closing edge, then the released line stops showing the last bit
        @(negedge sys_clk) spi_le_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (2) @(negedge sys_clk);
    endtask : send
endmodule : spi_host_model
`default_nettype wire

//--- pll_div9_cfg_tb.sv
// Purpose: self-checking bench for the out9/divider configuration slice
// Assumes: host frames sent by spi_host_model, nvm copy from the bench
// Notes:   shadow words predict every output; a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module pll_div9_cfg_tb
    import pll_div9_pkg::*;
;
    // expected port image
    typedef struct packed {
        logic        buf_en;
        logic        bias;
        out9_std_t   std;
        logic        swing;
        logic        tree;
        logic        ld;
        logic [13:0] rd;
        logic [13:0] od;
    } exp_t;

    logic        sys_clk, rstn, spi_clk, spi_le_n, spi_mosi;
    logic        config_select_pin, nvm_ready, aux_buffer_enable;
    logic        aux_neg_bias_connect, out9_swing_high, clock_tree_aux;
    logic        cfg_loaded;
    logic [31:0] nvm_out9_word, nvm_div_word, nvm_mux_word;
    logic [31:0] sh9, sh10, sh11, w;  // shadow words and scratch
    logic [13:0] ref_divider, osc_divider;
    out9_std_t   out9_std;
    exp_t        expq[$];
    exp_t        e;
    int          n_errors, checks_done, cycles, i;
    event        sample_ev;

    pll_div9_cfg pll_div9_cfg_inst (.sys_clk(sys_clk), .rstn(rstn),
        .spi_clk(spi_clk), .spi_le_n(spi_le_n), .spi_mosi(spi_mosi),
        .config_select_pin(config_select_pin), .nvm_ready(nvm_ready),
        .nvm_out9_word(nvm_out9_word), .nvm_div_word(nvm_div_word),
        .nvm_mux_word(nvm_mux_word), .aux_buffer_enable(aux_buffer_enable),
        .aux_neg_bias_connect(aux_neg_bias_connect), .out9_std(out9_std),
        .out9_swing_high(out9_swing_high), .clock_tree_aux(clock_tree_aux),
        .ref_divider(ref_divider), .osc_divider(osc_divider),
        .cfg_loaded(cfg_loaded));

    spi_host_model spi_host_model_inst (.sys_clk(sys_clk),
        .spi_clk(spi_clk), .spi_le_n(spi_le_n), .spi_mosi(spi_mosi));

    // 125 MHz
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // hang guard, far above the ~3200 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // verdict in one place
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // divider fields
    task automatic cmp_div(input logic [13:0] got, input logic [13:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_div

    // control bits and standard code
    task automatic cmp_ctl(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_ctl

    // prediction from shadow words; code order is {x,y}
    function automatic exp_t predict();
        exp_t p;
        p.buf_en = !sh9[24] && (sh11[24] || sh11[25]);
        p.bias   = sh9[23];
        p.std    = config_select_pin ? out9_std_t'({sh9[30], sh9[31]})
                                     : out9_std_t'({sh9[28], sh9[29]});
        p.swing  = sh9[25] && (p.std == STD_LVPECL);
        p.tree   = sh11[24];
        p.ld     = nvm_ready;
        p.rd     = sh10[17:4];
        p.od     = sh10[31:18];
        return p;
    endfunction : predict

    // note the expectation, then tell the monitor to look
    task automatic check();
        expq.push_back(predict());
        -> sample_ev;
        @(negedge sys_clk);
    endtask : check

    // one frame; only whole frames after the load move the shadows
    task automatic wr(input logic [31:0] v, input int n);
        spi_host_model_inst.send(v, n);
        if (n == 32 && nvm_ready) begin
            case (v[3:0])
                4'h9: sh9 = v;
                4'hA: sh10 = v;
                4'hB: sh11 = v;
                default: ;  // unmapped address, ignored
            endcase
        end
        repeat (4) @(negedge sys_clk);
        check();
    endtask : wr

    // monitor: oldest note against the settled outputs
    always @(sample_ev) begin
        e = expq.pop_front();
        cmp_div(ref_divider, e.rd);
        cmp_div(osc_divider, e.od);
        cmp_ctl({1'b0, aux_buffer_enable}, {1'b0, e.buf_en});
        cmp_ctl({1'b0, aux_neg_bias_connect}, {1'b0, e.bias});
        cmp_ctl(out9_std, e.std);
        cmp_ctl({1'b0, out9_swing_high}, {1'b0, e.swing});
        cmp_ctl({1'b0, clock_tree_aux}, {1'b0, e.tree});
        cmp_ctl({1'b0, cfg_loaded}, {1'b0, e.ld});
    end

    // main sequence
    initial begin
        void'($urandom(16634));
        rstn = 1'b0;
        config_select_pin = 1'b0;
        nvm_ready = 1'b0;
        nvm_out9_word = {$urandom} & 32'hFFFFFFF0 | 32'h00000009;
        nvm_div_word = {$urandom} & 32'hFFFFFFF0 | 32'h0000000A;
        nvm_mux_word = {$urandom} & 32'hFFFFFFF0 | 32'h0000000B;
        {sh9, sh10, sh11} = '0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        check();
        // host word before the nonvolatile load is dropped
        wr(32'h1234567A, 32);
        nvm_ready = 1'b1;
        {sh9, sh10, sh11} = {nvm_out9_word, nvm_div_word, nvm_mux_word};
        repeat (4) @(negedge sys_clk);
        check();
        // every code in both select fields, random aux and mux bits
        for (i = 0; i < 16; i++) begin
            w = {$urandom};
            w[31:28] = {i[2], i[3], i[0], i[1]};
            wr({w[31:4], 4'h9}, 32);
            w = {$urandom};
            wr({w[31:4], 4'hB}, 32);
            config_select_pin = ~config_select_pin;
            repeat (3) @(negedge sys_clk);
            check();
        end
        // divider boundaries then random values
        wr(32'hFFFFFFFA, 32);
        wr(32'h0000000A, 32);
        for (i = 0; i < 6; i++) begin
            w = {$urandom};
            wr({w[31:4], 4'hA}, 32);
        end
        // refused: unmapped address and a short frame
        wr(32'hFFFFFFF3, 32);
        wr(32'h5555555A, 31);
        summarize();
    end
endmodule : pll_div9_cfg_tb
`default_nettype wire
